// *** verilog/slmfc_align.sv ***
// Frame clock and multiframe clock alignment to the reference edge
`timescale 1ns/1ns
module slmfc_align
  import slmfc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Reference input and detection gate
  input wire logic sysref_in,
  input wire logic sysref_gate_en,
  // Synchronization request from the receiver, active low
  input wire logic sync_req_n,
  // Frame and multiframe clocks
  output logic frame_clk,
  output logic lmfc_clk,
  output logic [SLMFC_FCNT_W-1:0] frame_phase,
  output logic [SLMFC_MCNT_W-1:0] lmfc_phase,
  // Link status
  output logic aligned,
  output logic link_up,
  output logic realign_pulse,
  output logic sync_request
);
  logic edge_det;
  logic in_phase;
  logic realign;
  logic [SLMFC_FCNT_W-1:0] fcnt_r;
  logic [SLMFC_MCNT_W-1:0] mcnt_r;
  logic [SLMFC_FCNT_W-1:0] fcnt_nxt;
  logic [SLMFC_MCNT_W-1:0] mcnt_nxt;
  slmfc_state_t state_r;
  logic link_r;
  logic realign_r;
  logic fclk_r;
  logic lclk_r;
  logic sync_r;

  slmfc_edge_det u_edge (
    .ref_clk(ref_clk),
    .reset(reset),
    .level_in(sysref_in),
    .gate_en(sysref_gate_en),
    .edge_pulse(edge_det)
  );

  // phase compare
  // An edge is in phase when it lands on the counters' wrap point
  assign in_phase = (fcnt_r == SLMFC_FCNT_LAST) && (mcnt_r == SLMFC_MCNT_LAST);
  assign realign = edge_det && (!in_phase || state_r == SLMFC_UNALIGNED);

  always_comb begin
    fcnt_nxt = fcnt_r + 2'h1;
    mcnt_nxt = mcnt_r;
    if (fcnt_r == SLMFC_FCNT_LAST) begin
      mcnt_nxt = mcnt_r + 5'h01;
    end
    // Realign treats the edge cycle as the wrap point; the next cycle starts at phase zero
    if (realign) begin
      fcnt_nxt = SLMFC_FCNT_RST;
      mcnt_nxt = SLMFC_MCNT_RST;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fcnt_r <= SLMFC_FCNT_RST;
      mcnt_r <= SLMFC_MCNT_RST;
    end else begin
      fcnt_r <= fcnt_nxt;
      mcnt_r <= mcnt_nxt;
    end
  end

  // burst first edge
  // A gap in the bursts is harmless: an in-phase first edge keeps alignment
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_r <= SLMFC_UNALIGNED;
    end else if (realign) begin
      state_r <= SLMFC_ALIGNED;
    end
  end

  // drop link
  // Link is down for the realign cycle and returns once counters restart
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      link_r <= 1'b0;
      realign_r <= 1'b0;
    end else begin
      realign_r <= realign;
      link_r <= !realign && (state_r == SLMFC_ALIGNED || link_r);
    end
  end

  // Clock outputs high in the first half of each period
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fclk_r <= 1'b1;
      lclk_r <= 1'b1;
    end else begin
      fclk_r <= (fcnt_nxt < SLMFC_FCNT_HALF);
      lclk_r <= (mcnt_nxt < SLMFC_MCNT_HALF);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sync_r <= 1'b0;
    end else begin
      sync_r <= !sync_req_n;
    end
  end

  assign frame_clk = fclk_r;
  assign lmfc_clk = lclk_r;
  assign frame_phase = fcnt_r;
  assign lmfc_phase = mcnt_r;
  assign aligned = (state_r == SLMFC_ALIGNED);
  assign link_up = link_r;
  assign realign_pulse = realign_r;
  assign sync_request = sync_r;

  // Steps of a realign, of a kept edge and of a link restart
  sequence s_realign_seen;
    edge_det && (!in_phase || !aligned);
  endsequence
  sequence s_counters_zero;
    fcnt_r == SLMFC_FCNT_RST && mcnt_r == SLMFC_MCNT_RST;
  endsequence
  sequence s_kept_edge;
    edge_det && in_phase && aligned;
  endsequence
  sequence s_link_back;
    !link_up ##1 link_up;
  endsequence

  AST_REALIGN_ZERO: assert property (@(posedge ref_clk) disable iff (reset)
    s_realign_seen |=> s_counters_zero) else $error("counters not zeroed after realign");
  AST_REALIGN_DROPS_LINK: assert property (@(posedge ref_clk) disable iff (reset)
    s_realign_seen |=> !link_up && realign_pulse) else $error("link not dropped on mismatch");
  AST_MATCH_KEEPS: assert property (@(posedge ref_clk) disable iff (reset)
    edge_det && in_phase && aligned && link_up |=> link_up && fcnt_r == SLMFC_FCNT_RST
    && mcnt_r == SLMFC_MCNT_RST) else $error("matching edge disturbed link");
  AST_FIRST_EDGE: assert property (@(posedge ref_clk) disable iff (reset)
    edge_det && !aligned |=> aligned) else $error("first edge did not align");
  AST_FREE_RUN: assert property (@(posedge ref_clk) disable iff (reset)
    !edge_det && fcnt_r == SLMFC_FCNT_LAST |=> fcnt_r == SLMFC_FCNT_RST
    && mcnt_r == $past(mcnt_r) + 5'h01) else $error("multiframe not advanced");
  AST_FRAME_STEP: assert property (@(posedge ref_clk) disable iff (reset)
    !edge_det && fcnt_r != SLMFC_FCNT_LAST |=> fcnt_r == $past(fcnt_r) + 2'h1
    && mcnt_r == $past(mcnt_r)) else $error("frame counter misstep");
  AST_COMPARE: assert property (@(posedge ref_clk) disable iff (reset)
    edge_det && !in_phase |=> realign_pulse ##1 link_up == aligned) else $error("mismatch not realigned");
  AST_SYNC: assert property (@(posedge ref_clk) disable iff (reset)
    !sync_req_n |=> sync_request) else $error("sync request missed");
  AST_KEEP_NO_PULSE: assert property (@(posedge ref_clk) disable iff (reset)
    s_kept_edge |=> !realign_pulse && aligned) else $error("in phase edge caused realign");
  AST_LINK_BACK: assert property (@(posedge ref_clk) disable iff (reset)
    realign_pulse |-> s_link_back) else $error("link did not return after realign");
  AST_PULSE_SINGLE: assert property (@(posedge ref_clk) disable iff (reset)
    realign_pulse |=> !realign_pulse) else $error("realign pulse too long");
  AST_STAYS_ALIGNED: assert property (@(posedge ref_clk) disable iff (reset)
    aligned |=> aligned) else $error("alignment lost without reset");
  AST_BURST_FIRST: assert property (@(posedge ref_clk) disable iff (reset)
    edge_det && !aligned |=> realign_pulse) else $error("first edge gave no realign pulse");
  AST_NO_EDGE_QUIET: assert property (@(posedge ref_clk) disable iff (reset)
    !edge_det |=> !realign_pulse) else $error("realign without a detected edge");
  AST_FRAME_CLK: assert property (@(posedge ref_clk) disable iff (reset)
    frame_clk == (frame_phase < SLMFC_FCNT_HALF)) else $error("frame clock out of step with phase");
  AST_LMFC_CLK: assert property (@(posedge ref_clk) disable iff (reset)
    lmfc_clk == (lmfc_phase < SLMFC_MCNT_HALF)) else $error("multiframe clock out of step with phase");
  AST_RESET_STATE: assert property (@(posedge ref_clk)
    reset |=> frame_phase == SLMFC_FCNT_RST && lmfc_phase == SLMFC_MCNT_RST && !aligned && !link_up
    && !realign_pulse) else $error("reset state wrong");
endmodule

// *** verilog/slmfc_pkg.sv ***
// Package of constants for the frame clock and multiframe clock alignment block
package slmfc_pkg;
  // Samples per frame, frames per multiframe
  localparam int SLMFC_FRAME_LEN = 4;
  localparam int SLMFC_K = 32;
  localparam int SLMFC_FCNT_W = 2;
  localparam int SLMFC_MCNT_W = 5;
  localparam logic [SLMFC_FCNT_W-1:0] SLMFC_FCNT_RST = 2'h0;
  localparam logic [SLMFC_MCNT_W-1:0] SLMFC_MCNT_RST = 5'h00;
  localparam logic [SLMFC_FCNT_W-1:0] SLMFC_FCNT_LAST = 2'h3;
  localparam logic [SLMFC_MCNT_W-1:0] SLMFC_MCNT_LAST = 5'h1F;
  // First phase of the low half of each clock output
  localparam logic [SLMFC_FCNT_W-1:0] SLMFC_FCNT_HALF = 2'h2;
  localparam logic [SLMFC_MCNT_W-1:0] SLMFC_MCNT_HALF = 5'h10;
  // Tolerance for asynchronous edges, in frame clock cycles
  localparam int SLMFC_ASYNC_TOL_FRAMES = 2;
  typedef enum logic [1:0] {SLMFC_UNALIGNED, SLMFC_ALIGNED} slmfc_state_t;
endpackage

// *** verilog/slmfc_edge_det.sv ***
// Gated rising edge detector for the reference input
`timescale 1ns/1ns
module slmfc_edge_det (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Reference level and gate
  input wire logic level_in,
  input wire logic gate_en,
  // Detected edge
  output logic edge_pulse
);
  logic gated_r;
  // detection gate
  // Enabling the gate while high reads as an edge, as the hardware gate does
  // gate enable edge
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      gated_r <= 1'b0;
    end else begin
      gated_r <= level_in & gate_en;
    end
  end
  assign edge_pulse = (level_in & gate_en) & ~gated_r;

  AST_GATE_BLOCKS: assert property (@(posedge ref_clk) disable iff (reset)
    !gate_en |-> !edge_pulse) else $error("edge passed a closed gate");
  AST_GATE_OPEN_HIGH: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(gate_en) && level_in && !$past(level_in & gate_en) |-> edge_pulse)
    else $error("gate opening on high level not seen as edge");
endmodule

// *** tb/slmfc_ref_src.sv ***
// Clock generator model that launches reference pulses
`timescale 1ns/1ns
module slmfc_ref_src (
  // Clock
  input wire logic ref_clk,
  // Reference level
  output logic ref_level
);
  initial begin
    ref_level = 1'h0;
  end
  task automatic pulse(input int w);
    ref_level = 1'h1;
    repeat (w) @(negedge ref_clk);
    ref_level = 1'h0;
  endtask
endmodule

// *** tb/sysref_lmfc_alignment_test.sv ***
// Self-checking bench for the frame and multiframe clock alignment block
`timescale 1ns/1ns
module sysref_lmfc_alignment_test;
  import slmfc_pkg::*;
  logic ref_clk, reset, sysref_in, sysref_gate_en, sync_req_n, frame_clk, lmfc_clk;
  logic aligned, link_up, realign_pulse, sync_request, al, prev, det, live;
  logic [SLMFC_FCNT_W-1:0] frame_phase;
  logic [SLMFC_MCNT_W-1:0] lmfc_phase;
  logic [SLMFC_FCNT_W+SLMFC_MCNT_W-1:0] ph;
  logic [31:0] seed = 32'h25;
  logic [31:0] r;
  int errors, num_checks, cyc, lr = -9;
  int exp_q[$];
  slmfc_ref_src src (.ref_clk(ref_clk), .ref_level(sysref_in));
  slmfc_align uut (.ref_clk(ref_clk), .reset(reset), .sysref_in(sysref_in), .sysref_gate_en(sysref_gate_en),
    .sync_req_n(sync_req_n), .frame_clk(frame_clk), .lmfc_clk(lmfc_clk), .frame_phase(frame_phase),
    .lmfc_phase(lmfc_phase), .aligned(aligned), .link_up(link_up), .realign_pulse(realign_pulse),
    .sync_request(sync_request));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'h1) begin
      errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic stop_test();
    if (exp_q.size() != 0) errors++;
    if (errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wait_ph(input logic [6:0] p);
    do @(negedge ref_clk); while (ph !== p);
  endtask
  initial begin
    ref_clk = 1'h0;
    forever #50 ref_clk = ~ref_clk;
  end
  // Reference phase model; an edge at the last sample while aligned is in phase
  // The edge memory is cleared by reset, as in the block
  always @(posedge ref_clk) begin
    cyc++;
    det = sysref_in & sysref_gate_en & !prev;
    live = !reset;
    if (reset) begin
      ph = '0;
      al = 1'h0;
      prev = 1'h0;
    end else begin
      if (det && !(al && ph == 7'h7F)) begin
        exp_q.push_back(cyc);
        lr = cyc;
        ph = '0;
        al = 1'h1;
      end else ph = ph + 1'h1;
      prev = sysref_in & sysref_gate_en;
    end
    if (cyc > 20000) begin
      errors++;
      stop_test();
    end
  end
  always @(negedge ref_clk) begin
    if (live) begin
      check({lmfc_phase, frame_phase} === ph && aligned === al, "phase or state");
      check(frame_clk === (ph[1:0] < SLMFC_FCNT_HALF) && lmfc_clk === (ph[6:2] < SLMFC_MCNT_HALF), "clocks");
      check(sync_request === !sync_req_n, "sync request");
      check(link_up === (al && cyc != lr), "link state");
      if (realign_pulse === 1'h1) begin
        check(exp_q.size() > 0 && exp_q.pop_front() == cyc && link_up === 1'h0, "realign");
      end
    end
    r = rnd();
    sync_req_n = r[3];
  end
  initial begin
    reset = 1'h1;
    sysref_gate_en = 1'h1;
    sync_req_n = 1'h1;
    repeat (5) @(negedge ref_clk);
    reset = 1'h0;
    repeat (200) @(negedge ref_clk);
    src.pulse(8);
    repeat (4) begin
      wait_ph(7'h7F);
      src.pulse(16);
    end
    wait_ph(7'h40);
    src.pulse(16);
    @(negedge ref_clk);
    sysref_gate_en = 1'h0;
    src.pulse(16);
    @(negedge ref_clk);
    fork
      src.pulse(30);
      begin
        repeat (10) @(negedge ref_clk);
        sysref_gate_en = 1'h1;
      end
    join
    repeat (20) begin
      r = rnd();
      sysref_gate_en = r[0];
      repeat (1 + r[7:1]) @(negedge ref_clk);
      if (r[13]) wait_ph(7'h7F);
      src.pulse(8 + r[12:8]);
    end
    repeat (10) @(negedge ref_clk);
    stop_test();
  end
endmodule
